// ### hdl/iod_pkg.sv
// Package: addresses, field positions, masks and opcodes of the I/O space
package iod_pkg;

    // ****************************************************************
    // Address space
    // ****************************************************************
    localparam logic [5:0] IO_ADDR_LAST  = 6'h3F;
    localparam logic [5:0] BIT_ADDR_LAST = 6'h1F;
    localparam logic [7:0] DATA_SPACE_OFS = 8'h20;
    localparam logic [7:0] DATA_SPACE_END = 8'h5F;
    localparam int         LOW_REGS      = 32;

    localparam logic [4:0] ADR_DIG_IN_DIS   = 5'h01;
    localparam logic [4:0] ADR_BAUD_HI      = 5'h02;
    localparam logic [4:0] ADR_FRAME_FMT    = 5'h03;
    localparam logic [4:0] ADR_COMP_CS      = 5'h08;
    localparam logic [4:0] ADR_BAUD_LO      = 5'h09;
    localparam logic [4:0] ADR_USART_CTRL   = 5'h0A;
    localparam logic [4:0] ADR_USART_STAT   = 5'h0B;
    localparam logic [4:0] ADR_USART_DATA   = 5'h0C;
    localparam logic [4:0] ADR_SER_CTRL     = 5'h0D;
    localparam logic [4:0] ADR_SER_STAT     = 5'h0E;
    localparam logic [4:0] ADR_SER_SHIFT    = 5'h0F;
    localparam logic [4:0] ADR_PD_PIN       = 5'h10;
    localparam logic [4:0] ADR_PD_DIR       = 5'h11;
    localparam logic [4:0] ADR_PD_OUT       = 5'h12;
    localparam logic [4:0] ADR_SCRATCH0     = 5'h13;
    localparam logic [4:0] ADR_SCRATCH1     = 5'h14;
    localparam logic [4:0] ADR_SCRATCH2     = 5'h15;
    localparam logic [4:0] ADR_PB_PIN       = 5'h16;
    localparam logic [4:0] ADR_PB_DIR       = 5'h17;
    localparam logic [4:0] ADR_PB_OUT       = 5'h18;
    localparam logic [4:0] ADR_PA_PIN       = 5'h19;
    localparam logic [4:0] ADR_PA_DIR       = 5'h1B;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_RX_DONE   = 7;
    localparam int BIT_TX_DONE   = 6;
    localparam int BIT_TX_EMPTY  = 5;
    localparam int BIT_FRAME_ERR = 4;
    localparam int BIT_OVERRUN   = 3;
    localparam int BIT_PARITY    = 2;
    localparam int BIT_RX_BIT8   = 1;
    localparam int BIT_CMP_OUT   = 5;
    localparam int BIT_CMP_FLAG  = 4;
    localparam int BIT_SER_START = 7;
    localparam int BIT_SER_OVF   = 6;
    localparam int BIT_SER_STOP  = 5;
    localparam int BIT_SER_COLL  = 4;

    localparam logic [7:0] REG_RESET = 8'h00;

    // ****************************************************************
    // Opcodes seen from the core
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_IO_READ            = 3'h0,
        OP_IO_WRITE           = 3'h1,
        SET_SINGLE_BIT_OP     = 3'h2,
        CLEAR_SINGLE_BIT_OP   = 3'h3,
        SKIP_IF_BIT_SET_OP    = 3'h4,
        SKIP_IF_BIT_CLEAR_OP  = 3'h5,
        DATA_SPACE_LOAD_OP    = 3'h6,
        DATA_SPACE_STORE_OP   = 3'h7
    } iod_op_t;

    // ****************************************************************
    // Per-register bit classes
    // ****************************************************************
    function automatic logic [7:0] wr_mask(input logic [4:0] a);
        case (a)
            ADR_DIG_IN_DIS: wr_mask = 8'h03;
            ADR_BAUD_HI:    wr_mask = 8'h0F;
            ADR_FRAME_FMT:  wr_mask = 8'h7F;
            ADR_COMP_CS:    wr_mask = 8'hCF;
            ADR_USART_CTRL: wr_mask = 8'hFD;
            ADR_USART_STAT: wr_mask = 8'h03;
            ADR_SER_STAT:   wr_mask = 8'h0F;
            ADR_PD_DIR,
            ADR_PD_OUT:     wr_mask = 8'h7F;
            ADR_PA_DIR:     wr_mask = 8'h07;
            ADR_BAUD_LO, ADR_SER_CTRL, ADR_SER_SHIFT, ADR_SCRATCH0,
            ADR_SCRATCH1, ADR_SCRATCH2, ADR_PB_DIR,
            ADR_PB_OUT:     wr_mask = 8'hFF;
            default:        wr_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] w1c_mask(input logic [4:0] a);
        case (a)
            ADR_COMP_CS:    w1c_mask = 8'h10;
            ADR_USART_STAT: w1c_mask = 8'h40;
            ADR_SER_STAT:   w1c_mask = 8'hE0;
            default:        w1c_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] live_mask(input logic [4:0] a);
        case (a)
            ADR_COMP_CS:    live_mask = 8'h20;
            ADR_USART_CTRL: live_mask = 8'h02;
            ADR_USART_STAT: live_mask = 8'hBC;
            ADR_USART_DATA: live_mask = 8'hFF;
            ADR_SER_STAT:   live_mask = 8'h10;
            ADR_PD_PIN:     live_mask = 8'h7F;
            ADR_PB_PIN:     live_mask = 8'hFF;
            ADR_PA_PIN:     live_mask = 8'h07;
            default:        live_mask = 8'h00;
        endcase
    endfunction

endpackage

// ### hdl/iod_bitop_if.sv
// Interface: carrier between the decoder and the bit-operation unit
`timescale 1ns/1ps
`default_nettype none
interface iod_bitop_if;
    import iod_pkg::*;
    iod_op_t    op;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
    logic [7:0] old_val;
    logic [7:0] w1c_bits;
    logic [7:0] new_val;
    logic [7:0] clr_bits;
    logic       bit_val;

    modport user (output op, bit_sel, wdata, old_val, w1c_bits,
                  input  new_val, clr_bits, bit_val);
    modport unit (input  op, bit_sel, wdata, old_val, w1c_bits,
                  output new_val, clr_bits, bit_val);
endinterface
`default_nettype wire

// ### hdl/iod_bitop.sv
// Bit-operation unit: merged write value, flag clears and bit test
`timescale 1ns/1ps
`default_nettype none
module iod_bitop
    import iod_pkg::*;
(
    iod_bitop_if.unit bo
);
    logic [7:0] sel;

    always_comb begin
        sel         = 8'h01 << bo.bit_sel;
        bo.bit_val  = bo.old_val[bo.bit_sel];
        bo.new_val  = bo.old_val;
        bo.clr_bits = 8'h00;
        case (bo.op)
            OP_IO_WRITE, DATA_SPACE_STORE_OP: begin
                bo.new_val  = bo.wdata;
                bo.clr_bits = bo.wdata & bo.w1c_bits;
            end
            SET_SINGLE_BIT_OP: begin
                bo.new_val  = bo.old_val | sel;
                bo.clr_bits = sel & bo.w1c_bits;
            end
            CLEAR_SINGLE_BIT_OP: begin
                bo.new_val  = bo.old_val & ~sel;
            end
            default: begin
                bo.new_val  = bo.old_val;
            end
        endcase
    end
endmodule
`default_nettype wire

// ### hdl/iod_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module iod_pin_sync #(
    parameter int W = 19
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Pins and filtered result
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] pin_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Take a bit once stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                pin_q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                pin_q[i] <= s3_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// ### hdl/iod_io_space.sv
// Lower I/O register space: decode, storage, bit ops and peripheral taps
`timescale 1ns/1ps
`default_nettype none
module iod_io_space
    import iod_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,

    // Core request
    input  wire logic       io_req,
    input  wire iod_op_t    io_op,
    input  wire logic [7:0] io_addr,
    input  wire logic [2:0] io_bit,
    input  wire logic [7:0] io_wdata,

    // Core response
    output logic            resp_valid,
    output logic            resp_hit,
    output logic            resp_skip,
    output logic [7:0]      resp_rdata,

    // Port pins
    input  wire logic [2:0] port_a_pin_i,
    input  wire logic [7:0] port_b_pin_i,
    input  wire logic [6:0] port_d_pin_i,
    output logic [2:0]      port_a_dir,
    output logic [7:0]      port_b_o,
    output logic [7:0]      port_b_oe,
    output logic [6:0]      port_d_o,
    output logic [6:0]      port_d_oe,

    // Serial port status and data
    input  wire logic       usart_rx_done,
    input  wire logic       usart_tx_empty,
    input  wire logic       usart_frame_err,
    input  wire logic       usart_overrun,
    input  wire logic       usart_parity_err,
    input  wire logic       usart_rx_bit8,
    input  wire logic [7:0] usart_rx_data,
    input  wire logic       usart_tx_done_evt,
    output logic            usart_tx_load,
    output logic [7:0]      usart_tx_data,
    output logic            usart_rx_taken,
    output logic [7:0]      usart_ctrl,
    output logic [6:0]      usart_frame_cfg,
    output logic [11:0]     usart_baud,
    output logic [1:0]      usart_speed_cfg,

    // Analog comparator
    input  wire logic       comp_out_i,
    input  wire logic       comp_edge_evt,
    output logic [7:0]      comp_ctrl,
    output logic [1:0]      comp_in_disable,

    // Universal serial interface
    input  wire logic       usi_start_evt,
    input  wire logic       usi_ovf_evt,
    input  wire logic       usi_stop_evt,
    input  wire logic       usi_collision,
    output logic [7:0]      usi_ctrl,
    output logic [3:0]      usi_count,
    output logic [7:0]      usi_shift_data
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]  regs_q [LOW_REGS];
    logic [7:0]  evt_set [LOW_REGS];
    logic [18:0] pins_q;

    logic [4:0]  idx;
    logic        in_space;
    logic        low_hit;
    logic        is_bit_op;
    logic        is_write;
    logic        is_read;

    logic        do_write;
    logic        tx_wr;

    logic [7:0]  live_val;
    logic [7:0]  rd_val;
    logic [7:0]  keep_bits;
    logic        skip_d;

    // To the bit-op unit
    iod_bitop_if bo_if ();

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Order: comp, D, B, A
    iod_pin_sync #(
        .W (19)
    ) u_pin_sync (
        .clk   (clk),
        .rst   (rst),
        .pin_i ({comp_out_i, port_d_pin_i, port_b_pin_i, port_a_pin_i}),
        .pin_q (pins_q)
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    always_comb begin
        in_space  = 1'b0;
        idx       = 5'h00;
        is_bit_op = 1'b0;
        is_write  = 1'b0;
        is_read   = 1'b0;
        case (io_op)
            OP_IO_READ, OP_IO_WRITE: begin
                in_space = (io_addr <= {2'b00, IO_ADDR_LAST});
                idx      = io_addr[4:0];
                is_write = (io_op == OP_IO_WRITE);
                is_read  = (io_op == OP_IO_READ);
            end
            // data space seen at I/O address plus offset
            DATA_SPACE_LOAD_OP, DATA_SPACE_STORE_OP: begin
                in_space = (io_addr >= DATA_SPACE_OFS) &&
                           (io_addr <= DATA_SPACE_END);
                idx      = 5'(io_addr - DATA_SPACE_OFS);
                is_write = (io_op == DATA_SPACE_STORE_OP);
                is_read  = (io_op == DATA_SPACE_LOAD_OP);
            end
            // bit ops only reach the low 32 addresses
            SET_SINGLE_BIT_OP, CLEAR_SINGLE_BIT_OP,
            SKIP_IF_BIT_SET_OP, SKIP_IF_BIT_CLEAR_OP: begin
                in_space  = (io_addr <= {2'b00, BIT_ADDR_LAST});
                idx       = io_addr[4:0];
                is_bit_op = 1'b1;
                is_write  = (io_op == SET_SINGLE_BIT_OP) ||
                            (io_op == CLEAR_SINGLE_BIT_OP);
            end
            default: begin
                in_space = 1'b0;
            end
        endcase
    end

    // Upper half of the space lies outside this block
    always_comb begin
        if (is_bit_op) begin
            low_hit = io_req && in_space;
        end else if ((io_op == DATA_SPACE_LOAD_OP) ||
                     (io_op == DATA_SPACE_STORE_OP)) begin
            low_hit = io_req && in_space &&
                      (io_addr < (DATA_SPACE_OFS + 8'(LOW_REGS)));
        end else begin
            low_hit = io_req && in_space && !io_addr[5];
        end
    end

    // Writes need a hit in this block
    assign do_write = low_hit && is_write;

    // No strobe on bit ops
    assign tx_wr = low_hit && !is_bit_op && is_write &&
                   (idx == ADR_USART_DATA);

    // ****************************************************************
    // Live values from peripherals and pins
    // ****************************************************************
    always_comb begin
        live_val = 8'h00;
        case (idx)
            ADR_COMP_CS:    live_val[BIT_CMP_OUT] = pins_q[18];
            ADR_USART_CTRL: live_val[BIT_RX_BIT8] = usart_rx_bit8;
            ADR_USART_STAT: begin
                live_val[BIT_RX_DONE]   = usart_rx_done;
                live_val[BIT_TX_EMPTY]  = usart_tx_empty;
                live_val[BIT_FRAME_ERR] = usart_frame_err;
                live_val[BIT_OVERRUN]   = usart_overrun;
                live_val[BIT_PARITY]    = usart_parity_err;
            end
            ADR_USART_DATA: live_val = usart_rx_data;
            ADR_SER_STAT:   live_val[BIT_SER_COLL] = usi_collision;
            ADR_PD_PIN:     live_val = {1'b0, pins_q[17:11]};
            ADR_PB_PIN:     live_val = pins_q[10:3];
            ADR_PA_PIN:     live_val = {5'h00, pins_q[2:0]};
            default:        live_val = 8'h00;
        endcase
    end

    // reserved bits and addresses read zero
    always_comb begin
        keep_bits = wr_mask(idx) | w1c_mask(idx);
        rd_val    = (regs_q[idx] & keep_bits) | (live_val & live_mask(idx));
    end

    // ****************************************************************
    // Bit-operation unit
    // ****************************************************************
    assign bo_if.op       = io_op;
    assign bo_if.bit_sel  = io_bit;
    assign bo_if.wdata    = io_wdata;
    // Bit test sees live bits
    assign bo_if.old_val  = rd_val;
    assign bo_if.w1c_bits = w1c_mask(idx);

    iod_bitop u_bitop (
        .bo (bo_if.unit)
    );

    // ****************************************************************
    // Hardware flag events
    // ****************************************************************
    // Peripheral pulses
    always_comb begin
        for (int i = 0; i < LOW_REGS; i++) begin
            evt_set[i] = 8'h00;
        end
        evt_set[ADR_USART_STAT][BIT_TX_DONE]  = usart_tx_done_evt;
        evt_set[ADR_COMP_CS][BIT_CMP_FLAG]    = comp_edge_evt;
        evt_set[ADR_SER_STAT][BIT_SER_START]  = usi_start_evt;
        evt_set[ADR_SER_STAT][BIT_SER_OVF]    = usi_ovf_evt;
        evt_set[ADR_SER_STAT][BIT_SER_STOP]   = usi_stop_evt;
    end

    // ****************************************************************
    // Register storage
    // ****************************************************************
    for (genvar g = 0; g < LOW_REGS; g++) begin : g_reg
        localparam logic [4:0] A = 5'(g);
        logic [7:0] wm;
        logic [7:0] fm;
        logic [7:0] reg_d;

        assign wm = wr_mask(A);
        assign fm = w1c_mask(A);

        always_comb begin
            reg_d = regs_q[g];
            if (do_write && (idx == A)) begin
                reg_d = (regs_q[g] & ~wm) | (bo_if.new_val & wm);
                reg_d = reg_d & ~(bo_if.clr_bits & fm);
            end
            // Set wins over a clear in the same cycle
            reg_d = (reg_d & (wm | fm)) | (evt_set[g] & fm);
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                regs_q[g] <= REG_RESET;
            end else begin
                regs_q[g] <= reg_d;
            end
        end
    end

    // ****************************************************************
    // Response to the core
    // ****************************************************************
    // test of the selected bit
    always_comb begin
        case (io_op)
            SKIP_IF_BIT_SET_OP:   skip_d = low_hit && bo_if.bit_val;
            SKIP_IF_BIT_CLEAR_OP: skip_d = low_hit && !bo_if.bit_val;
            default:              skip_d = 1'b0;
        endcase
    end

    // One pulse per request
    always_ff @(posedge clk) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_hit   <= 1'b0;
            resp_skip  <= 1'b0;
        end else begin
            resp_valid <= io_req;
            resp_hit   <= low_hit;
            resp_skip  <= skip_d;
        end
    end

    // Holds until next request
    always_ff @(posedge clk) begin
        if (rst) begin
            resp_rdata <= 8'h00;
        end else if (io_req) begin
            resp_rdata <= (low_hit && is_read) ? rd_val : 8'h00;
        end
    end

    // ****************************************************************
    // Serial data register side effects
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            usart_tx_load  <= 1'b0;
            usart_rx_taken <= 1'b0;
        end else begin
            usart_tx_load  <= tx_wr;
            usart_rx_taken <= low_hit && is_read &&
                              (idx == ADR_USART_DATA);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            usart_tx_data <= 8'h00;
        end else if (tx_wr) begin
            usart_tx_data <= io_wdata;
        end
    end

    // ****************************************************************
    // Register taps toward pins and peripherals
    // ****************************************************************
    // Reserved bits masked
    assign port_a_dir      = regs_q[ADR_PA_DIR][2:0];
    assign port_b_o        = regs_q[ADR_PB_OUT];
    assign port_b_oe       = regs_q[ADR_PB_DIR];
    assign port_d_o        = regs_q[ADR_PD_OUT][6:0];
    assign port_d_oe       = regs_q[ADR_PD_DIR][6:0];
    assign usart_ctrl      = regs_q[ADR_USART_CTRL] & wr_mask(ADR_USART_CTRL);
    assign usart_frame_cfg = regs_q[ADR_FRAME_FMT][6:0];
    assign usart_baud      = {regs_q[ADR_BAUD_HI][3:0], regs_q[ADR_BAUD_LO]};
    assign usart_speed_cfg = regs_q[ADR_USART_STAT][1:0];
    assign comp_ctrl       = regs_q[ADR_COMP_CS] & wr_mask(ADR_COMP_CS);
    assign comp_in_disable = regs_q[ADR_DIG_IN_DIS][1:0];
    assign usi_ctrl        = regs_q[ADR_SER_CTRL];
    assign usi_count       = regs_q[ADR_SER_STAT][3:0];
    assign usi_shift_data  = regs_q[ADR_SER_SHIFT];

endmodule
`default_nettype wire

// ### verification/iod_io_space_assertions.sv
// Checker: response timing, range decode and write effects
`timescale 1ns/1ps
`default_nettype none
module iod_io_space_assertions
    import iod_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       io_req,
    input wire iod_op_t    io_op,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic       resp_valid,
    input wire logic       resp_hit,
    input wire logic       resp_skip,
    input wire logic [7:0] resp_rdata,
    input wire logic       usart_tx_load,
    input wire logic [7:0] usart_tx_data,
    input wire logic [7:0] port_b_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    resp_once_a: assert property (io_req |=> resp_valid)
        else $error("no response after request");
    resp_quiet_a: assert property (!io_req |=> !resp_valid && $stable(resp_rdata))
        else $error("response without request");
    bit_range_a: assert property (io_req && io_op inside {SET_SINGLE_BIT_OP,
        CLEAR_SINGLE_BIT_OP, SKIP_IF_BIT_SET_OP, SKIP_IF_BIT_CLEAR_OP}
        && io_addr > 8'h1F |=> !resp_hit && !resp_skip)
        else $error("bit op accepted above bit range");
    io_range_a: assert property (io_req && io_op inside {OP_IO_READ, OP_IO_WRITE}
        |=> resp_hit == ($past(io_addr) < 8'h20))
        else $error("io address decode wrong");
    data_ofs_a: assert property (io_req && io_op inside {DATA_SPACE_LOAD_OP,
        DATA_SPACE_STORE_OP} |=> resp_hit == ($past(io_addr) inside {[8'h20:8'h3F]}))
        else $error("data space decode wrong");
    skip_ops_a: assert property (io_req && !(io_op inside {SKIP_IF_BIT_SET_OP,
        SKIP_IF_BIT_CLEAR_OP}) |=> !resp_skip)
        else $error("skip raised by non test op");
    tx_load_a: assert property (io_req && io_op == OP_IO_WRITE && io_addr == 8'h0C
        |=> usart_tx_load && usart_tx_data == $past(io_wdata))
        else $error("transmit strobe missing");
    store_ofs_a: assert property (io_req && io_op == DATA_SPACE_STORE_OP
        && io_addr == 8'h38 |=> port_b_o == $past(io_wdata))
        else $error("store did not reach port b");
    resv_read_a: assert property (io_req && io_op == OP_IO_READ
        && io_addr inside {[8'h04:8'h07]} |=> resp_rdata == 8'h00)
        else $error("reserved address read not zero");
endmodule
bind iod_io_space iod_io_space_assertions chk_i (.clk, .rst, .io_req, .io_op,
    .io_addr, .io_wdata, .resp_valid, .resp_hit, .resp_skip, .resp_rdata,
    .usart_tx_load, .usart_tx_data, .port_b_o);
`default_nettype wire

// ### verification/iod_core_model.sv
// Core model: issues one-cycle requests and collects the responses
`timescale 1ns/1ps
`default_nettype none
module iod_core_model
    import iod_pkg::*;
(
    input  wire logic       clk,
    output var iod_op_t     io_op,
    output logic            io_req,
    output logic [7:0]      io_addr,
    output logic [2:0]      io_bit,
    output logic [7:0]      io_wdata,
    input  wire logic       resp_hit,
    input  wire logic       resp_skip,
    input  wire logic [7:0] resp_rdata
);
    initial begin
        io_req = 1'b0;
        io_op = OP_IO_READ;
        io_addr = 8'h00;
        io_bit = 3'h0;
        io_wdata = 8'h00;
    end
    // reserved bits zero, no reserved address writes
    task automatic access(input iod_op_t op, input logic [7:0] a,
        input logic [2:0] b, input logic [7:0] d, output logic [7:0] rd,
        output logic h, output logic s);
        @(negedge clk);
        io_req = 1'b1;
        io_op = op;
        io_addr = a;
        io_bit = b;
        io_wdata = d;
        @(negedge clk);
        io_req = 1'b0;
        io_addr = ~io_addr;
        io_bit = ~io_bit;
        io_wdata = ~io_wdata;
        rd = resp_rdata;
        h = resp_hit;
        s = resp_skip;
    endtask
endmodule
`default_nettype wire

// ### verification/test_io_register_space_decode.sv
// Testbench: decode, bit operations, flags and pins of the I/O space
`timescale 1ns/1ps
`default_nettype none
module test_io_register_space_decode;
    import iod_pkg::*;
    logic clk, rst, io_req, resp_valid, resp_hit, resp_skip, usart_tx_load;
    logic h, s, tx_evt;
    iod_op_t io_op;
    logic [7:0] io_addr, io_wdata, resp_rdata, port_b_o, port_b_oe, rd;
    logic [7:0] usart_tx_data, port_b_pin_i, rx_byte;
    logic [2:0] io_bit, port_a_pin_i;
    logic [6:0] port_d_pin_i;
    logic [11:0] sts;
    int n_errors = 0;
    int total_checks = 0;
    iod_io_space dut (.clk, .rst, .io_req, .io_op, .io_addr, .io_bit,
        .io_wdata, .resp_valid, .resp_hit, .resp_skip, .resp_rdata,
        .port_a_pin_i, .port_b_pin_i, .port_d_pin_i, .port_a_dir(),
        .port_b_o, .port_b_oe, .port_d_o(), .port_d_oe(),
        .usart_rx_done(sts[0]), .usart_tx_empty(sts[1]),
        .usart_frame_err(sts[2]), .usart_overrun(sts[3]),
        .usart_parity_err(sts[4]), .usart_rx_bit8(sts[5]),
        .usart_rx_data(rx_byte), .usart_tx_done_evt(tx_evt), .usart_tx_load,
        .usart_tx_data, .usart_rx_taken(), .usart_ctrl(), .usart_frame_cfg(),
        .usart_baud(), .usart_speed_cfg(), .comp_out_i(sts[6]),
        .comp_edge_evt(sts[7]), .comp_ctrl(), .comp_in_disable(),
        .usi_start_evt(sts[8]), .usi_ovf_evt(sts[9]), .usi_stop_evt(sts[10]),
        .usi_collision(sts[11]), .usi_ctrl(), .usi_count(), .usi_shift_data());
    iod_core_model core (.clk, .io_op, .io_req, .io_addr, .io_bit, .io_wdata,
        .resp_hit, .resp_skip, .resp_rdata);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task finish_test;
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        core.access(OP_IO_READ, a, 3'h0, 8'h00, rd, h, s);
        chk(nm, e, rd);
    endtask
    task t_rw;
        core.access(OP_IO_WRITE, 8'h18, 3'h0, 8'hA5, rd, h, s);
        chk("port b out", 8'hA5, port_b_o);
        rdchk(8'h18, 8'hA5, "in 0x18");
        core.access(DATA_SPACE_LOAD_OP, 8'h38, 3'h0, 8'h00, rd, h, s);
        chk("load 0x38", 8'hA5, rd);
        core.access(DATA_SPACE_STORE_OP, 8'h37, 3'h0, 8'h3C, rd, h, s);
        chk("port b oe", 8'h3C, port_b_oe);
        core.access(OP_IO_WRITE, 8'h0C, 3'h0, 8'h5E, rd, h, s);
        chk("tx data", 8'h5E, usart_tx_data);
        core.access(OP_IO_WRITE, 8'h38, 3'h0, 8'h00, rd, h, s);
        chk("out 0x38 hit", 8'h00, {7'h00, h});
        chk("port b kept", 8'hA5, port_b_o);
    endtask
    task t_bits;
        core.access(SET_SINGLE_BIT_OP, 8'h18, 3'h3, 8'h00, rd, h, s);
        chk("set bit3", 8'hAD, port_b_o);
        core.access(CLEAR_SINGLE_BIT_OP, 8'h18, 3'h0, 8'h00, rd, h, s);
        chk("clear bit0", 8'hAC, port_b_o);
        core.access(SKIP_IF_BIT_SET_OP, 8'h18, 3'h2, 8'h00, rd, h, s);
        chk("skip set", 8'h01, {7'h00, s});
        core.access(SKIP_IF_BIT_CLEAR_OP, 8'h18, 3'h2, 8'h00, rd, h, s);
        chk("skip clear b2", 8'h00, {7'h00, s});
        core.access(SKIP_IF_BIT_CLEAR_OP, 8'h18, 3'h0, 8'h00, rd, h, s);
        chk("skip clear b0", 8'h01, {7'h00, s});
        core.access(SET_SINGLE_BIT_OP, 8'h38, 3'h0, 8'h00, rd, h, s);
        chk("bit op high", 8'hAC, port_b_o);
    endtask
    task t_flags;
        @(negedge clk);
        {tx_evt, sts[7]} = 2'b11;
        @(negedge clk);
        {tx_evt, sts[7]} = 2'b00;
        rdchk(8'h0B, 8'h40, "flag set");
        rdchk(8'h08, 8'h10, "comp flag");
        core.access(SET_SINGLE_BIT_OP, 8'h08, 3'h4, 8'h00, rd, h, s);
        rdchk(8'h08, 8'h00, "comp flag set op");
        core.access(CLEAR_SINGLE_BIT_OP, 8'h0B, 3'h6, 8'h00, rd, h, s);
        rdchk(8'h0B, 8'h40, "flag after clear op");
        core.access(SET_SINGLE_BIT_OP, 8'h0B, 3'h1, 8'h00, rd, h, s);
        rdchk(8'h0B, 8'h42, "flag after set op");
        core.access(OP_IO_WRITE, 8'h0B, 3'h0, 8'h02, rd, h, s);
        rdchk(8'h0B, 8'h42, "zero write");
        core.access(OP_IO_WRITE, 8'h0B, 3'h0, 8'h40, rd, h, s);
        rdchk(8'h0B, 8'h00, "one write");
    endtask
    task t_resv;
        rdchk(8'h05, 8'h00, "reserved read");
        chk("reserved hit", 8'h01, {7'h00, h});
        rdchk(8'h25, 8'h00, "in 0x25");
        core.access(DATA_SPACE_STORE_OP, 8'h58, 3'h0, 8'h11, rd, h, s);
        chk("store 0x58 hit", 8'h00, {7'h00, h});
        rx_byte = 8'h3C;
        rdchk(8'h0C, 8'h3C, "rx data");
    endtask
    task t_pins;
        port_b_pin_i = 8'h5A;
        repeat (5) @(negedge clk);
        rdchk(8'h16, 8'h5A, "pin b");
        core.access(OP_IO_WRITE, 8'h16, 3'h0, 8'hFF, rd, h, s);
        rdchk(8'h16, 8'h5A, "pin b read only");
    endtask
    initial begin
        #(20 * 2000);
        n_errors++;
        finish_test;
    end
    initial begin
        rst = 1'b1;
        tx_evt = 1'b0;
        sts = 12'h000;
        rx_byte = 8'h00;
        port_a_pin_i = 3'h0;
        port_b_pin_i = 8'h00;
        port_d_pin_i = 7'h00;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_rw;
        t_bits;
        t_flags;
        t_resv;
        t_pins;
        finish_test;
    end
endmodule
`default_nettype wire
